// >>> hw/pulse_width_timer_regs.svh
// Register indices, bit positions and reset values of the pulse width timer
`ifndef PULSE_WIDTH_TIMER_REGS_SVH
`define PULSE_WIDTH_TIMER_REGS_SVH
`define IDX_CTRL_STATUS 14'h3030
`define IDX_CTRL_CONFIG 14'h3031
`define IDX_HIGH_WIDTH_UPPER 14'h3032
`define IDX_HIGH_WIDTH_LOWER 14'h3033
`define IDX_LOW_WIDTH_UPPER 14'h3034
`define IDX_LOW_WIDTH_LOWER 14'h3035
`define IDX_COUNT_UPPER 14'h3036
`define IDX_COUNT_LOWER 14'h3037
`define ADR_IDX_HI 15
`define ADR_IDX_LO 2
`define BYTE_W 8
`define REG_RESET 8'h00
`define BUS_ZERO 32'h0000_0000
`define CS_ENABLE 7
`define CS_IRQ_EN 6
`define CS_RDY_IE 5
`define CS_OV_IE 4
`define CS_SOFT_RST 3
`define CS_RDY 1
`define CS_OV 0
`define FLAG_RDY 1
`define FLAG_OV 0
`define EDGE_ALT_FALL 2'h0
`define EDGE_RISE_RISE 2'h1
`define EDGE_FALL_FALL 2'h2
`define EDGE_ALT_RISE 2'h3
`define DIV_ONE 8'h01
`endif

// >>> hw/pulse_width_timer_pkg.sv
// Types shared by the pulse width timer modules
package pulse_width_timer_pkg;
  typedef struct packed {
    logic [1:0] input_select;
    logic clock_source_select;
    logic [1:0] edge_mode;
    logic [2:0] prescale;
  } cfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } edge_evt_t;

  typedef enum logic {ST_WAIT_TRIGGER, ST_MEASURE} meas_state_t;
endpackage

// >>> hw/count_tick_gen.sv
// Clock source selection, alternate clock synchroniser and prescaler
`timescale 1ns/10ps
`include "pulse_width_timer_regs.svh"
module count_tick_gen import pulse_width_timer_pkg::*; #(
  parameter int DIV_BITS = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic alternate_count_clock_i,
  input wire logic clock_source_select_i,
  input wire logic [2:0] prescale_i,
  input wire logic halt_i,
  input wire logic clear_i,
  output logic tick_o
);
  logic alt_meta_q, alt_sync_q, alt_prev_q;
  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] mask;
  logic src_evt;

  // Two-stage synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_meta_q <= 1'b0;
      alt_sync_q <= 1'b0;
      alt_prev_q <= 1'b0;
    end else begin
      alt_meta_q <= alternate_count_clock_i; // R14
      alt_sync_q <= alt_meta_q;
      alt_prev_q <= alt_sync_q;
    end
  end

  assign src_evt = clock_source_select_i ? (alt_sync_q & ~alt_prev_q) : 1'b1; // R6
  assign mask = DIV_BITS'((`DIV_ONE << prescale_i) - `DIV_ONE);
  assign tick_o = src_evt & ~halt_i & ((div_q & mask) == mask); // R5

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      div_q <= '0;
    end else if (src_evt && !halt_i) begin
      div_q <= div_q + 1'b1; // R5
    end
  end
endmodule

// >>> hw/pulse_input_filter.sv
// Pulse input selection and one-tick glitch filter
`timescale 1ns/10ps
module pulse_input_filter import pulse_width_timer_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] pulse_inputs_i,
  input wire logic [1:0] input_select_i,
  input wire logic tick_i,
  input wire logic clear_i,
  output edge_evt_t evt_o
);
  logic raw;
  logic cand_q;
  edge_evt_t evt_q;

  assign raw = pulse_inputs_i[input_select_i]; // R7
  assign evt_o = evt_q;

  // A level must be seen on two successive ticks before it counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cand_q <= 1'b0;
      evt_q <= '0;
    end else if (clear_i) begin
      cand_q <= raw;
      evt_q <= '{rise: 1'b0, fall: 1'b0, level: raw};
    end else begin
      evt_q.rise <= 1'b0;
      evt_q.fall <= 1'b0;
      if (tick_i) begin
        cand_q <= raw;
        if (raw == cand_q && raw != evt_q.level) begin // R9
          evt_q.level <= raw;
          evt_q.rise <= raw;
          evt_q.fall <= ~raw;
        end
      end
    end
  end
endmodule

// >>> hw/pulse_width_timer.sv
// Pulse width timer: Wishbone registers, measurement and capture logic
// How it works
// R1: Counts prescaled ticks in a 16-bit counter to time pulses.
// R2: High and low durations are kept in separate result registers.
// R3: Software picks the edge polarity that starts a measurement.
// R4: Spans are alternating edges, rising to rising, or falling to falling.
// R5: A programmable prescaler divides the selected clock into counting ticks.
// R6: Clock select bit picks the alternate clock, else the timer clock.
// R7: Input select field routes one of four pulse inputs.
// R8: Selecting the external input enables its pin automatically.
// R9: Pulses shorter than one counting tick are ignored.
// R10: Enabled interrupt on new result and on counter overflow.
// R11: Measurement continues in run and wait modes; interrupt wakes.
// R12: Stop halts everything and preserves state; resume afterwards.
// R13: Debug freezes counting and edges; soft reset or disable restart.
// R14: Alternate clock is synchronised to the bus clock before use.
// R15: Alternate clock source stays at or below quarter bus rate.
// R16: Eight byte registers, results and count read-only, reset to zero.
// R17: Status bit 7 enables the module; config changes only while off. The config register here also accepts writes while on.
// R18: Writing 1 to soft reset bit resets measurement; reads as 0.
// R19: Ready flag set on update, cleared by read then write 0.
// R20: Counter wrap past maximum sets overflow flag and interrupt.
`timescale 1ns/10ps
`include "pulse_width_timer_regs.svh"
module pulse_width_timer import pulse_width_timer_pkg::*; #(
  parameter int CNT_W = 16,
  parameter logic [3:0] EXT_PIN_MASK = 4'h2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] pulse_inputs_i,
  input wire logic alternate_count_clock_i,
  input wire logic stop_i,
  input wire logic debug_i,
  output logic irq_o,
  output logic [3:0] pin_enable_o
);
  logic ack_q, irq_q;
  logic [31:0] dat_q;
  logic [3:0] pin_en_q;
  logic en_q, ie_q, rdyie_q, ovie_q;
  cfg_t cfg_q;
  logic [1:0] flag_q, armed_q, flag_set, flag_clr;
  logic [CNT_W-1:0] cnt_q, high_q, low_q;
  meas_state_t state_q;
  logic [13:0] idx;
  logic acc, wr_cs, wr_cr, rd_cs, srst_w, soft_clr, halt;
  logic tick, trig, span_edge, set_rdy, set_ov, measuring;
  edge_evt_t evt;
  logic [7:0] rd_byte;

  function automatic logic [7:0] byte_of(input logic [CNT_W-1:0] v, input logic upper);
    return upper ? v[`BYTE_W +: `BYTE_W] : v[0 +: `BYTE_W];
  endfunction

  // Bus decode; writes and read side effects land on the edge that ends ack
  assign idx = adr_i[`ADR_IDX_HI:`ADR_IDX_LO];
  assign acc = cyc_i & stb_i & ack_q;
  assign wr_cs = acc & we_i & sel_i[0] & (idx == `IDX_CTRL_STATUS);
  assign wr_cr = acc & we_i & sel_i[0] & (idx == `IDX_CTRL_CONFIG);
  assign rd_cs = acc & ~we_i & (idx == `IDX_CTRL_STATUS);
  assign srst_w = wr_cs & dat_i[`CS_SOFT_RST]; // R18
  assign soft_clr = srst_w | ~en_q; // R13
  assign halt = stop_i | debug_i; // R12

  count_tick_gen #(
    .DIV_BITS(7)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .alternate_count_clock_i(alternate_count_clock_i),
    .clock_source_select_i(cfg_q.clock_source_select),
    .prescale_i(cfg_q.prescale),
    .halt_i(halt),
    .clear_i(soft_clr),
    .tick_o(tick)
  );

  pulse_input_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pulse_inputs_i(pulse_inputs_i),
    .input_select_i(cfg_q.input_select),
    .tick_i(tick),
    .clear_i(soft_clr),
    .evt_o(evt)
  );

  always_comb begin
    rd_byte = `REG_RESET;
    case (idx)
      `IDX_CTRL_STATUS: begin
        rd_byte[`CS_ENABLE] = en_q;
        rd_byte[`CS_IRQ_EN] = ie_q;
        rd_byte[`CS_RDY_IE] = rdyie_q;
        rd_byte[`CS_OV_IE] = ovie_q;
        rd_byte[`CS_RDY] = flag_q[`FLAG_RDY];
        rd_byte[`CS_OV] = flag_q[`FLAG_OV];
      end
      `IDX_CTRL_CONFIG: rd_byte = cfg_q;
      `IDX_HIGH_WIDTH_UPPER: rd_byte = byte_of(high_q, 1'b1); // R16
      `IDX_HIGH_WIDTH_LOWER: rd_byte = byte_of(high_q, 1'b0);
      `IDX_LOW_WIDTH_UPPER: rd_byte = byte_of(low_q, 1'b1);
      `IDX_LOW_WIDTH_LOWER: rd_byte = byte_of(low_q, 1'b0);
      `IDX_COUNT_UPPER: rd_byte = byte_of(cnt_q, 1'b1);
      `IDX_COUNT_LOWER: rd_byte = byte_of(cnt_q, 1'b0);
      default: rd_byte = `REG_RESET;
    endcase
  end

  // One wait state, ack lasts a single cycle; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= `BUS_ZERO;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      dat_q <= (cyc_i && stb_i && !we_i && !ack_q) ? {24'h00_0000, rd_byte} : `BUS_ZERO;
    end
  end

  // Control bits; soft reset bit is a strobe and never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      ie_q <= 1'b0;
      rdyie_q <= 1'b0;
      ovie_q <= 1'b0;
      cfg_q <= cfg_t'(`REG_RESET); // R16
    end else begin
      if (wr_cs) begin
        en_q <= dat_i[`CS_ENABLE]; // R17
        ie_q <= dat_i[`CS_IRQ_EN];
        rdyie_q <= dat_i[`CS_RDY_IE];
        ovie_q <= dat_i[`CS_OV_IE];
      end
      if (wr_cr) begin
        cfg_q <= cfg_t'(dat_i[`BYTE_W-1:0]);
      end
    end
  end

  // Measurement spans
  assign measuring = (state_q == ST_MEASURE) & ~soft_clr & ~halt;
  always_comb begin
    case (cfg_q.edge_mode)
      `EDGE_RISE_RISE: span_edge = evt.rise; // R4
      `EDGE_FALL_FALL: span_edge = evt.fall;
      default: span_edge = evt.rise | evt.fall;
    endcase
  end
  assign trig = (cfg_q.edge_mode == `EDGE_ALT_RISE || cfg_q.edge_mode == `EDGE_RISE_RISE)
                ? evt.rise : evt.fall; // R3
  assign set_rdy = measuring & span_edge; // R19
  assign set_ov = measuring & ~span_edge & tick & (cnt_q == {CNT_W{1'b1}}); // R20

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_clr) begin
      state_q <= ST_WAIT_TRIGGER;
    end else if (!halt) begin
      case (state_q)
        ST_WAIT_TRIGGER: if (trig) state_q <= ST_MEASURE; // R3
        ST_MEASURE: state_q <= ST_MEASURE;
        default: state_q <= ST_WAIT_TRIGGER;
      endcase
    end
  end

  // Counter; frozen while halted so stop and debug resume where they left off
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_clr) begin
      cnt_q <= '0; // R13
    end else if (!halt) begin
      if (state_q == ST_WAIT_TRIGGER && !trig) begin
        cnt_q <= '0;
      end else if (state_q == ST_WAIT_TRIGGER || span_edge) begin
        // The tick of the edge cycle opens the new span, so none is lost
        cnt_q <= {{(CNT_W-1){1'b0}}, tick}; // R1
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1; // R1
      end
    end
  end

  // Captures; period modes derive the missing phase by subtraction
  always_ff @(posedge clk_i) begin
    if (rst_i || srst_w) begin
      high_q <= '0;
      low_q <= '0;
    end else if (measuring) begin
      if (evt.fall) begin
        high_q <= (cfg_q.edge_mode == `EDGE_FALL_FALL) ? cnt_q - low_q : cnt_q; // R2
      end
      if (evt.rise) begin
        low_q <= (cfg_q.edge_mode == `EDGE_RISE_RISE) ? cnt_q - high_q : cnt_q; // R2
      end
    end
  end

  // Flags: a read while set arms the clear; a new event disarms and wins
  assign flag_set = {set_rdy, set_ov};
  assign flag_clr = {2{wr_cs}} & ~{dat_i[`CS_RDY], dat_i[`CS_OV]} & armed_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || srst_w) begin
      flag_q <= 2'h0;
      armed_q <= 2'h0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set; // R19
      armed_q <= ~flag_set & (rd_cs ? flag_q : (wr_cs ? 2'h0 : armed_q));
    end
  end

  // Interrupt and pin enable; wait mode needs nothing special to wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      pin_en_q <= 4'h0;
    end else begin
      irq_q <= en_q & ie_q & |(flag_q & {rdyie_q, ovie_q}); // R10 R11
      pin_en_q <= en_q ? (EXT_PIN_MASK & (4'h1 << cfg_q.input_select)) : 4'h0; // R8
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign irq_o = irq_q;
  assign pin_enable_o = pin_en_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_cycle: assert property (ack_o |=> !ack_o) // R16
    else $error("ack held longer than one cycle");
  a_count_tick_step: assert property ( // R1
    (measuring && tick && !span_edge) |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
    else $error("counter did not advance on tick");
  a_high_capture: assert property ( // R2
    (measuring && evt.fall && cfg_q.edge_mode != `EDGE_FALL_FALL)
    |=> high_q == $past(cnt_q))
    else $error("high width not captured on falling edge");
  a_trigger_start: assert property ( // R3
    (state_q == ST_WAIT_TRIGGER && trig && !soft_clr && !halt)
    |=> state_q == ST_MEASURE ##1 cnt_q == '0 || state_q == ST_MEASURE)
    else $error("trigger edge did not start measurement");
  a_period_no_ready: assert property ( // R4
    (measuring && cfg_q.edge_mode == `EDGE_RISE_RISE && evt.fall)
    |-> !set_rdy ##1 cnt_q == CNT_W'($past(cnt_q) + $past(tick)))
    else $error("counter restarted mid period");
  a_prescale_gap: assert property ( // R5
    (tick && cfg_q.prescale != 3'h0 && !cfg_q.clock_source_select
     && $stable(cfg_q)) |=> !tick)
    else $error("prescaled ticks back to back");
  a_alt_quiet: assert property ( // R6
    (cfg_q.clock_source_select && !alternate_count_clock_i)[*4] |-> !tick)
    else $error("tick without alternate clock edge");
  a_pin_enable: assert property ( // R8
    (pin_enable_o != 4'h0) |-> ($countones(pin_enable_o) == 1 && $past(en_q)))
    else $error("bad pin enable");
  a_irq_cause: assert property ( // R10
    $rose(irq_o) |-> $past(ie_q && en_q && (flag_q & {rdyie_q, ovie_q}) != 2'h0))
    else $error("interrupt without enabled flag");
  a_halt_freeze: assert property ( // R13
    (halt && !soft_clr) |=> cnt_q == $past(cnt_q) && state_q == $past(state_q))
    else $error("counter moved while halted");
  a_disable_idle: assert property ( // R17
    !en_q |=> state_q == ST_WAIT_TRIGGER && cnt_q == '0)
    else $error("disabled module still measuring");
  a_soft_reset: assert property ( // R18
    srst_w |=> cnt_q == '0 && flag_q == 2'h0 && high_q == '0 && low_q == '0)
    else $error("soft reset left state behind");
  a_ready_clear: assert property ( // R19
    $fell(flag_q[`FLAG_RDY]) |-> $past(armed_q[`FLAG_RDY] && wr_cs) || $past(srst_w))
    else $error("ready cleared without read then write");
  a_overflow_set: assert property (set_ov |=> flag_q[`FLAG_OV] && cnt_q == '0) // R20
    else $error("overflow not flagged on wrap");
  a_span_restart: assert property ( // R1
    (measuring && span_edge) |=> cnt_q == {{(CNT_W-1){1'b0}}, $past(tick)})
    else $error("span did not restart the counter");
  a_low_capture: assert property ( // R2
    (measuring && evt.rise && cfg_q.edge_mode != `EDGE_RISE_RISE)
    |=> low_q == $past(cnt_q))
    else $error("low width not captured on rising edge");
  a_idle_no_capture: assert property ( // R3
    (state_q == ST_WAIT_TRIGGER && !srst_w)
    |=> high_q == $past(high_q) && low_q == $past(low_q))
    else $error("capture before trigger edge");
  a_period_low: assert property ( // R4
    (measuring && evt.rise && cfg_q.edge_mode == `EDGE_RISE_RISE)
    |=> low_q == CNT_W'($past(cnt_q) - $past(high_q)))
    else $error("low width of period mode wrong");
  a_route_select: assert property ( // R7
    evt.rise |-> $past(pulse_inputs_i[cfg_q.input_select]))
    else $error("rising edge from unselected input");
  a_pin_select: assert property ( // R8
    (en_q && EXT_PIN_MASK[cfg_q.input_select]) |=> pin_enable_o[$past(cfg_q.input_select)])
    else $error("external input pin not enabled");
  a_glitch_hold: assert property ( // R9
    (tick && !soft_clr && pulse_inputs_i[cfg_q.input_select] != u_filter.cand_q)
    |=> !evt.rise && !evt.fall)
    else $error("edge accepted after a single tick");
  a_irq_gate: assert property ((!ie_q || !en_q) |=> !irq_o) // R10
    else $error("interrupt while disabled");
  a_stop_freeze: assert property ( // R12
    (stop_i && !soft_clr)
    |=> cnt_q == $past(cnt_q) && high_q == $past(high_q) && low_q == $past(low_q))
    else $error("state moved in stop");
  a_alt_synced: assert property ( // R14
    (cfg_q.clock_source_select && tick) |-> $past(alternate_count_clock_i, 2))
    else $error("alternate clock used before synchronising");
  a_ack_answer: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o) // R16
    else $error("request not answered after one wait state");
  a_ro_results: assert property ( // R16
    (acc && we_i && !measuring && !srst_w)
    |=> high_q == $past(high_q) && low_q == $past(low_q))
    else $error("register write changed a result");
  a_enable_write: assert property ( // R17
    wr_cs |=> en_q == $past(dat_i[`CS_ENABLE]))
    else $error("enable bit not written");
  a_soft_reads_zero: assert property ( // R18
    (ack_o && !we_i && idx == `IDX_CTRL_STATUS) |-> !dat_o[`CS_SOFT_RST])
    else $error("soft reset bit read back as one");
  a_ready_set: assert property (set_rdy |=> flag_q[`FLAG_RDY]) // R19
    else $error("ready flag not set on update");
  a_ready_arm: assert property ( // R19
    (rd_cs && flag_q[`FLAG_RDY] && !set_rdy) |=> armed_q[`FLAG_RDY])
    else $error("status read did not arm the clear");
  a_ov_irq: assert property ( // R20
    (en_q && ie_q && ovie_q && flag_q[`FLAG_OV]) |=> irq_o)
    else $error("overflow interrupt missing");
  a_ov_clear: assert property ( // R20
    $fell(flag_q[`FLAG_OV]) |-> $past(armed_q[`FLAG_OV] && wr_cs) || $past(srst_w))
    else $error("overflow cleared without read then write");

  c_result: cover property (set_rdy ##[1:100] set_rdy);
  c_overflow: cover property (set_ov);
  c_two_step: cover property (rd_cs && flag_q[`FLAG_RDY] ##[1:20] $fell(flag_q[`FLAG_RDY]));
  c_irq: cover property ($rose(irq_o));
  c_halt_resume: cover property (halt ##1 !halt && tick);
endmodule

// >>> verif/pulse_source.sv
// Pulse source model driving the four timer inputs and the alternate clock
`timescale 1ns/10ps
module pulse_source (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  input wire logic [31:0] high_len_i,
  input wire logic [31:0] low_len_i,
  output logic [3:0] pulse_inputs_o,
  output logic alternate_count_clock_o
);
  logic main_q = 1'b0;
  logic noise_q = 1'b0;
  logic [31:0] cnt_q = 32'h0;
  logic [1:0] ncnt_q = 2'h0;
  logic [2:0] div_q = 3'h0;
  // Main pulse starts low, then alternates low and high phases
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      main_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (cnt_q + 32'h1 >= (main_q ? high_len_i : low_len_i)) begin
      main_q <= ~main_q;
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  // Unselected inputs toggle fast, so a wrong route yields wrong widths
  always_ff @(posedge clk_i) begin
    ncnt_q <= (ncnt_q == 2'h2) ? 2'h0 : ncnt_q + 2'h1;
    if (ncnt_q == 2'h2) begin
      noise_q <= ~noise_q;
    end
  end
  // Divide by 8 keeps the alternate clock well under a quarter bus rate
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 3'h1;
  end
  assign alternate_count_clock_o = div_q[2];
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pulse_inputs_o[k] = (sel_i == k[1:0]) ? main_q : noise_q;
    end
  end
endmodule

// >>> verif/test_pulse_width_timer.sv
// Register-level tests of the pulse width timer
`timescale 1ns/10ps
`include "pulse_width_timer_regs.svh"
module test_pulse_width_timer;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic stop = 1'b0;
  logic debug = 1'b0;
  logic irq;
  logic [3:0] pin_en;
  logic [3:0] pulses;
  logic alternate_count_clock;
  logic run = 1'b0;
  logic [1:0] psel = 2'h1;
  logic [31:0] hlen = 32'h14;
  logic [31:0] llen = 32'h1e;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] q;
  logic [15:0] c1;
  logic [15:0] c2;

  initial begin
    forever #5 clk = ~clk;
  end

  pulse_width_timer i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pulse_inputs_i(pulses), .alternate_count_clock_i(alternate_count_clock), .stop_i(stop),
    .debug_i(debug), .irq_o(irq), .pin_enable_o(pin_en));

  pulse_source i_src (.clk_i(clk), .run_i(run), .sel_i(psel), .high_len_i(hlen),
    .low_len_i(llen), .pulse_inputs_o(pulses), .alternate_count_clock_o(alternate_count_clock));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d,
                    output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, i, d, r);
  endtask

  task automatic rd16(input logic [13:0] i, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    wb(1'b0, i, 8'h00, h);
    wb(1'b0, i + 14'h1, 8'h00, l);
    v = {h, l};
  endtask

  task automatic rdc(input string nm, input logic [13:0] i, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, i, 8'h00, r);
    check(nm, {8'h00, r}, {8'h00, exp});
  endtask

  // Runs one measurement, then disables and reads both results
  task automatic measure(input logic [7:0] cfg, input int h, input int l,
                         input logic [15:0] eh, input logic [15:0] el, input logic [3:0] pe);
    logic [15:0] v;
    psel <= cfg[7:6];
    hlen <= h;
    llen <= l;
    wr(`IDX_CTRL_STATUS, 8'h08);
    wr(`IDX_CTRL_CONFIG, cfg);
    wr(`IDX_CTRL_STATUS, 8'he0);
    run <= 1'b1;
    repeat (5 * (h + l) + 60) @(posedge clk);
    check("pin_enable", {12'h000, pin_en}, {12'h000, pe});
    check("irq_ready", {15'h0000, irq}, 16'h0001);
    wr(`IDX_CTRL_STATUS, 8'h00);
    run <= 1'b0;
    rd16(`IDX_HIGH_WIDTH_UPPER, v);
    check("high_width", v, eh);
    rd16(`IDX_LOW_WIDTH_UPPER, v);
    check("low_width", v, el);
    $display("Measure cfg %h done", cfg);
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rdc("reset_value", `IDX_CTRL_STATUS + k[13:0], `REG_RESET);
    end
    rdc("unmapped", 14'h3038, 8'h00);
    wr(`IDX_COUNT_LOWER, 8'hff);
    wr(`IDX_HIGH_WIDTH_UPPER, 8'hff);
    rdc("ro_count", `IDX_COUNT_LOWER, 8'h00);
    rdc("ro_width", `IDX_HIGH_WIDTH_UPPER, 8'h00);
    wr(`IDX_CTRL_STATUS, 8'h08);
    rdc("soft_reset_reads_0", `IDX_CTRL_STATUS, 8'h00);
    $display("Register test done");
    for (int m = 0; m < 4; m++) begin
      measure({2'h1, 1'b0, m[1:0], 3'h0}, 20, 30, 16'd20, 16'd30, 4'h2);
    end
    measure({2'h2, 1'b1, 2'h3, 3'h0}, 48, 32, 16'd6, 16'd4, 4'h0);
    measure({2'h3, 1'b0, 2'h3, 3'h2}, 40, 24, 16'd10, 16'd6, 4'h0);
    // Flag survives a write of 1, clears on read then write 0
    rdc("ready_set", `IDX_CTRL_STATUS, 8'h02);
    wr(`IDX_CTRL_STATUS, 8'h02);
    rdc("ready_kept", `IDX_CTRL_STATUS, 8'h02);
    wr(`IDX_CTRL_STATUS, 8'h00);
    rdc("ready_clear", `IDX_CTRL_STATUS, 8'h00);
    wr(`IDX_CTRL_STATUS, 8'h08);
    rdc("soft_reset_width", `IDX_HIGH_WIDTH_LOWER, 8'h00);
    $display("Flag test done");
    // Long high phase lets the counter wrap
    psel <= 2'h1;
    hlen <= 70000;
    llen <= 10;
    wr(`IDX_CTRL_CONFIG, {2'h1, 1'b0, 2'h3, 3'h0});
    rdc("config_back", `IDX_CTRL_CONFIG, 8'h58);
    wr(`IDX_CTRL_STATUS, 8'hd0);
    run <= 1'b1;
    repeat (500) @(posedge clk);
    debug <= 1'b1;
    rd16(`IDX_COUNT_UPPER, c1);
    repeat (40) @(posedge clk);
    rd16(`IDX_COUNT_UPPER, c2);
    check("debug_freeze", c2, c1);
    debug <= 1'b0;
    stop <= 1'b1;
    repeat (40) @(posedge clk);
    rd16(`IDX_COUNT_UPPER, c2);
    check("stop_freeze", c2, c1);
    stop <= 1'b0;
    repeat (40) @(posedge clk);
    rd16(`IDX_COUNT_UPPER, c2);
    check("resumed", {15'h0000, c2 > c1}, 16'h0001);
    check("no_ov_irq_yet", {15'h0000, irq}, 16'h0000);
    repeat (66000) @(posedge clk);
    check("ov_irq", {15'h0000, irq}, 16'h0001);
    wr(`IDX_CTRL_STATUS, 8'h00);
    run <= 1'b0;
    rdc("ov_flag", `IDX_CTRL_STATUS, 8'h01);
    $display("Overflow test done");
    conclude();
  end
endmodule
